// ---- dv/lpw_wake_regs_tb.sv ----
// self-checking bench of the wake-up and retention register block
`timescale 1ns/1ps
module lpw_wake_regs_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic [31:0] port1_pin = 32'hFFFF_FFFF;
   logic [2:0] pwake = 3'h0;
   logic global_pin_wake_enable = 1'b0;
   logic wake_request;
   logic wake_irq;
   logic [3:0] ram_bank_pair_off;
   logic irq;
   logic [31:0] seed = 32'hECCC;
   int failures = 0;
   int total_checks = 0;
   int cyc = 0;

   // 5 ns period
   always #2.5 aclk = ~aclk;

   lpw_wake_regs DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port1_pin(port1_pin),
      .lowpower_serial_wake(pwake[2]), .lowpower_timer_b_wake(pwake[1]), .lowpower_timer_a_wake(pwake[0]),
      .global_pin_wake_enable(global_pin_wake_enable), .wake_request(wake_request), .wake_irq(wake_irq),
      .ram_bank_pair_off(ram_bank_pair_off), .irq(irq));

   // ----------------------------------------------------------------
   // compare, report and random helpers
   // ----------------------------------------------------------------
   task automatic report_and_stop;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic miss(input string m);
      failures++;
      $display("wrong value at %0t: %s", $time, m);
   endtask
   task automatic chk_data(input logic [31:0] g, input logic [31:0] e, input string m);
      total_checks++;
      if (g !== e)
         miss(m);
   endtask
   task automatic chk_resp(input logic [1:0] g, input logic [1:0] e, input string m);
      total_checks++;
      if (g !== e)
         miss(m);
   endtask
   task automatic chk_flag(input logic g, input logic e, input string m);
      total_checks++;
      if (g !== e)
         miss(m);
   endtask
   // xorshift keeps the run repeatable
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // ----------------------------------------------------------------
   // axi4-lite master: readiness is looked at mid-cycle, where it is settled
   // ----------------------------------------------------------------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta;
      logic tw;
      logic tb;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      r = 2'h3;
      for (int n = 0; n < 64; n++)
      begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         r = tb ? s_axi_bresp : r;
         @(posedge aclk);
         if (ta)
            s_axi_awvalid <= 1'b0;
         if (tw)
            s_axi_wvalid <= 1'b0;
         if (tb)
            break;
      end
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta;
      logic tr;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r = 2'h3;
      d = 32'h0;
      for (int n = 0; n < 64; n++)
      begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         d = tr ? s_axi_rdata : d;
         r = tr ? s_axi_rresp : r;
         @(posedge aclk);
         if (ta)
            s_axi_arvalid <= 1'b0;
         if (tr)
            break;
      end
      s_axi_rready <= 1'b0;
   endtask
   task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk_resp(r, lpw_pkg::RESP_OKAY, "write response");
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk_resp(r, lpw_pkg::RESP_OKAY, "read response");
      chk_data(d, e, m);
   endtask

   // a hang ends the run as a mismatch
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         failures++;
         report_and_stop();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [31:0] v;
      logic [31:0] m;
      logic [31:0] d;
      logic [1:0] r;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      // absent-pin bits stay at reset: the bench clears with all-ones words and once with a random word
      rd_chk(lpw_pkg::OFF_PORT1_WAKE_STATUS, 32'h0, "reset status");
      rd_chk(lpw_pkg::OFF_PERIPH_WAKE_ENABLE, 32'h0, "reset enable");
      rd_chk(lpw_pkg::OFF_RETAINED_SCRATCH_B, 32'h0, "reset scratch");
      wr_ok(lpw_pkg::OFF_PERIPH_WAKE_ENABLE, 32'hFFFF_FFFF);
      rd_chk(lpw_pkg::OFF_PERIPH_WAKE_ENABLE, 32'h7, "enable reserved");
      // each shutdown bit alone, then a random word with reserved bits set
      for (int i = 0; i < 5; i++)
      begin
         v = rnd();
         v = (i < 4) ? (32'h1 << i) : v;
         wr_ok(lpw_pkg::OFF_RAM_BANK_SHUTDOWN, v);
         rd_chk(lpw_pkg::OFF_RAM_BANK_SHUTDOWN, v & 32'hF, "shutdown word");
         chk_data({28'h0, ram_bank_pair_off}, v & 32'hF, "bank pair off");
      end
      v = rnd();
      m = rnd();
      wr_ok(lpw_pkg::OFF_RETAINED_SCRATCH_A, v);
      wr_ok(lpw_pkg::OFF_RETAINED_SCRATCH_B, m);
      wr_ok(lpw_pkg::OFF_RAM_BANK_SHUTDOWN, 32'h0);
      rd_chk(lpw_pkg::OFF_RETAINED_SCRATCH_A, v, "scratch a");
      rd_chk(lpw_pkg::OFF_RETAINED_SCRATCH_B, m, "scratch b");
      axi_wr(8'h20, v, r);
      chk_resp(r, lpw_pkg::RESP_SLVERR, "unmapped write");
      axi_rd(8'h20, d, r);
      chk_resp(r, lpw_pkg::RESP_SLVERR, "unmapped read");
      chk_data(d, 32'h0, "unmapped data");
      $display("test registers done");
      // falls latch sticky flags, the later rise leaves them; pins 0 and 31 always among them
      wr_ok(lpw_pkg::OFF_PORT1_WAKE_STATUS, 32'hFFFF_FFFF);
      m = rnd();
      m = m | 32'h8000_0001;
      port1_pin <= ~m;
      repeat (6) @(posedge aclk);
      port1_pin <= 32'hFFFF_FFFF;
      repeat (6) @(posedge aclk);
      rd_chk(lpw_pkg::OFF_PORT1_WAKE_STATUS, m, "pin flags");
      global_pin_wake_enable <= 1'b1;
      wr_ok(lpw_pkg::OFF_PORT1_WAKE_ENABLE, ~m);
      chk_flag(wake_request, 1'b0, "disjoint enable");
      wr_ok(lpw_pkg::OFF_PORT1_WAKE_ENABLE, 32'h8000_0000);
      chk_flag(wake_request, 1'b1, "pin wake");
      chk_flag(wake_irq, 1'b1, "pin wake irq");
      global_pin_wake_enable <= 1'b0;
      @(negedge aclk);
      chk_flag(wake_request, 1'b0, "global gate");
      global_pin_wake_enable <= 1'b1;
      v = rnd();
      wr_ok(lpw_pkg::OFF_PORT1_WAKE_STATUS, v);
      rd_chk(lpw_pkg::OFF_PORT1_WAKE_STATUS, m & ~v, "partial clear");
      wr_ok(lpw_pkg::OFF_PORT1_WAKE_STATUS, 32'hFFFF_FFFF);
      chk_flag(wake_request, 1'b0, "pin wake cleared");
      $display("test pins done");
      // one peripheral at a time: blocked first, then enabled
      for (int i = 0; i < 3; i++)
      begin
         wr_ok(lpw_pkg::OFF_PERIPH_WAKE_ENABLE, ~(32'h1 << i));
         pwake <= 3'h1 << i;
         repeat (6) @(posedge aclk);
         pwake <= 3'h0;
         repeat (2) @(posedge aclk);
         rd_chk(lpw_pkg::OFF_PERIPH_WAKE_STATUS, 32'h1 << i, "periph flag");
         chk_flag(wake_request, 1'b0, "periph blocked");
         wr_ok(lpw_pkg::OFF_PERIPH_WAKE_ENABLE, 32'h7);
         chk_flag(wake_irq, 1'b1, "periph wake");
         chk_flag(wake_request, 1'b1, "periph wake request");
         wr_ok(lpw_pkg::OFF_PERIPH_WAKE_STATUS, 32'h1 << i);
         chk_flag(wake_request, 1'b0, "periph cleared");
      end
      $display("test peripherals done");
      // both event kinds were seen: raise, mask and clear the interrupt
      rd_chk(lpw_pkg::OFF_IRQ_STATUS, 32'h3, "irq status");
      chk_flag(irq, 1'b0, "irq masked");
      wr_ok(lpw_pkg::OFF_IRQ_ENABLE, 32'h1);
      chk_flag(irq, 1'b1, "irq raised");
      wr_ok(lpw_pkg::OFF_IRQ_CLEAR, 32'h1);
      chk_flag(irq, 1'b0, "irq cleared");
      rd_chk(lpw_pkg::OFF_IRQ_STATUS, 32'h2, "irq status left");
      wr_ok(lpw_pkg::OFF_IRQ_ENABLE, 32'h3);
      chk_flag(irq, 1'b1, "irq second");
      wr_ok(lpw_pkg::OFF_IRQ_CLEAR, 32'h2);
      chk_flag(irq, 1'b0, "irq all clear");
      rd_chk(lpw_pkg::OFF_IRQ_CLEAR, 32'h0, "clear reads zero");
      $display("test interrupt done");
      report_and_stop();
   end
endmodule // lpw_wake_regs_tb

// ---- hw/lpw_evt_if.sv ----
// event carrier between the wake synchroniser and the register block
`timescale 1ns/1ps
interface lpw_evt_if;
   logic [lpw_pkg::PIN_W-1:0] pin_fall;
   logic [lpw_pkg::PERIPH_W-1:0] periph_rise;

   modport src (output pin_fall, output periph_rise);
   modport dst (input pin_fall, input periph_rise);
endinterface

// ---- hw/lpw_pkg.sv ----
// shared constants of the low-power wake and retention register block
package lpw_pkg;
   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int PIN_W = 32;
   localparam int PERIPH_W = 3;
   localparam int RAM_W = 4;
   localparam int IRQ_W = 2;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_PORT1_WAKE_STATUS = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_PORT1_WAKE_ENABLE = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_PERIPH_WAKE_STATUS = 8'h30;
   localparam logic [ADDR_W-1:0] OFF_PERIPH_WAKE_ENABLE = 8'h34;
   localparam logic [ADDR_W-1:0] OFF_RAM_BANK_SHUTDOWN = 8'h40;
   localparam logic [ADDR_W-1:0] OFF_RETAINED_SCRATCH_A = 8'h48;
   localparam logic [ADDR_W-1:0] OFF_RETAINED_SCRATCH_B = 8'h4C;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h50;
   localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h54;
   localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h58;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int BIT_LOWPOWER_SERIAL = 2;
   localparam int BIT_LOWPOWER_TIMER_B = 1;
   localparam int BIT_LOWPOWER_TIMER_A = 0;
   localparam int BIT_IRQ_PIN_EVENT = 0;
   localparam int BIT_IRQ_PERIPH_EVENT = 1;

   // ----------------------------------------------------------------
   // reset values and responses
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
   localparam logic [PERIPH_W-1:0] RST_PERIPH = 3'h0;
   localparam logic [RAM_W-1:0] RST_RAM = 4'h0;
   localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int SYNC_STAGES = 2;
endpackage

// ---- hw/lpw_wake_regs.sv ----
// wake-up source, ram shutdown and retained scratch registers behind axi4-lite
`timescale 1ns/1ps
module lpw_wake_regs
#(
   parameter logic [31:0] PIN_PRESENT = 32'hFFFF_FFFF
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] port1_pin,
   input wire logic lowpower_serial_wake,
   input wire logic lowpower_timer_b_wake,
   input wire logic lowpower_timer_a_wake,
   input wire logic global_pin_wake_enable,
   output logic wake_request,
   output logic wake_irq,
   output logic [3:0] ram_bank_pair_off,
   output logic irq
);
   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [31:0] port1_wake_status;
   logic [31:0] port1_wake_enable;
   logic [2:0] peripheral_wake_status;
   logic [2:0] peripheral_wake_enable;
   logic [3:0] ram_bank_shutdown;
   logic [31:0] retained_scratch_a;
   logic [31:0] retained_scratch_b;
   logic [1:0] irq_status;
   logic [1:0] irq_enable;

   lpw_evt_if ev ();

   lpw_wake_sync u_sync
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .port1_pin(port1_pin),
      .periph_wake({lowpower_serial_wake, lowpower_timer_b_wake, lowpower_timer_a_wake}),
      .ev(ev)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == lpw_pkg::OFF_PORT1_WAKE_STATUS) || (a == lpw_pkg::OFF_PORT1_WAKE_ENABLE) ||
         (a == lpw_pkg::OFF_PERIPH_WAKE_STATUS) || (a == lpw_pkg::OFF_PERIPH_WAKE_ENABLE) ||
         (a == lpw_pkg::OFF_RAM_BANK_SHUTDOWN) || (a == lpw_pkg::OFF_RETAINED_SCRATCH_A) ||
         (a == lpw_pkg::OFF_RETAINED_SCRATCH_B) || (a == lpw_pkg::OFF_IRQ_STATUS) ||
         (a == lpw_pkg::OFF_IRQ_CLEAR) || (a == lpw_pkg::OFF_IRQ_ENABLE);
   endfunction

   // ----------------------------------------------------------------
   // write channel: address and data held independently
   // ----------------------------------------------------------------
   logic aw_full;
   logic w_full;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic [31:0] wmask;
   logic [31:0] wbits;

   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready = !w_full && !s_axi_bvalid;
   assign wr_fire = aw_full && w_full && !s_axi_bvalid;
   assign wmask = strb_mask(w_strb);
   assign wbits = w_data & wmask;

   // hold each half until its partner arrives
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= lpw_pkg::RST_WORD;
         w_strb <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         else if (wr_fire)
            aw_full <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_full <= 1'b0;
      end
   end

   // write response, unmapped addresses answer slverr
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= lpw_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= addr_known(aw_addr) ? lpw_pkg::RESP_OKAY : lpw_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   logic wr_p1s;
   logic wr_pws;
   logic wr_icl;
   assign wr_p1s = wr_fire && (aw_addr == lpw_pkg::OFF_PORT1_WAKE_STATUS);
   assign wr_pws = wr_fire && (aw_addr == lpw_pkg::OFF_PERIPH_WAKE_STATUS);
   assign wr_icl = wr_fire && (aw_addr == lpw_pkg::OFF_IRQ_CLEAR);

   // ----------------------------------------------------------------
   // sticky wake flags; a new edge beats a same-cycle clear
   // ----------------------------------------------------------------
   logic [31:0] pin_set;
   assign pin_set = ev.pin_fall & PIN_PRESENT;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         port1_wake_status <= lpw_pkg::RST_WORD;
      else
         port1_wake_status <= (port1_wake_status & ~(wr_p1s ? wbits : 32'h0000_0000)) | pin_set;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         peripheral_wake_status <= lpw_pkg::RST_PERIPH;
      else
         peripheral_wake_status <= (peripheral_wake_status & ~(wr_pws ? wbits[2:0] : 3'h0)) | ev.periph_rise;
   end

   // ----------------------------------------------------------------
   // plain read-write registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         port1_wake_enable <= lpw_pkg::RST_WORD;
         peripheral_wake_enable <= lpw_pkg::RST_PERIPH;
         ram_bank_shutdown <= lpw_pkg::RST_RAM;
         irq_enable <= lpw_pkg::RST_IRQ;
      end
      else if (wr_fire)
      begin
         unique case (aw_addr)
            lpw_pkg::OFF_PORT1_WAKE_ENABLE:
               port1_wake_enable <= (port1_wake_enable & ~wmask) | wbits;
            lpw_pkg::OFF_PERIPH_WAKE_ENABLE:
               peripheral_wake_enable <= (peripheral_wake_enable & ~wmask[2:0]) | wbits[2:0];
            lpw_pkg::OFF_RAM_BANK_SHUTDOWN:
               ram_bank_shutdown <= (ram_bank_shutdown & ~wmask[3:0]) | wbits[3:0];
            lpw_pkg::OFF_IRQ_ENABLE:
               irq_enable <= (irq_enable & ~wmask[1:0]) | wbits[1:0];
            default:
               irq_enable <= irq_enable;
         endcase
      end
   end

   // scratch words reset only with the system reset, never on sleep entry or exit
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         retained_scratch_a <= lpw_pkg::RST_WORD;
         retained_scratch_b <= lpw_pkg::RST_WORD;
      end
      else
      begin
         if (wr_fire && aw_addr == lpw_pkg::OFF_RETAINED_SCRATCH_A)
            retained_scratch_a <= (retained_scratch_a & ~wmask) | wbits;
         if (wr_fire && aw_addr == lpw_pkg::OFF_RETAINED_SCRATCH_B)
            retained_scratch_b <= (retained_scratch_b & ~wmask) | wbits;
      end
   end

   // ----------------------------------------------------------------
   // wake request and interrupt merge
   // ----------------------------------------------------------------
   logic pin_wake;
   logic per_wake;
   // absent pins are masked so a stray enable bit cannot wake
   assign pin_wake = |(port1_wake_status & port1_wake_enable & PIN_PRESENT) && global_pin_wake_enable;
   assign per_wake = |(peripheral_wake_status & peripheral_wake_enable);
   assign wake_request = pin_wake || per_wake;
   assign wake_irq = pin_wake || per_wake;
   // power-off drops the bank supply, so the pair loses its data
   assign ram_bank_pair_off = ram_bank_shutdown;

   // event interrupts: new pin or peripheral flag
   logic [1:0] irq_set;
   assign irq_set[lpw_pkg::BIT_IRQ_PIN_EVENT] = |pin_set;
   assign irq_set[lpw_pkg::BIT_IRQ_PERIPH_EVENT] = |ev.periph_rise;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_status <= lpw_pkg::RST_IRQ;
      else
         irq_status <= (irq_status & ~(wr_icl ? wbits[1:0] : 2'h0)) | irq_set;
   end
   assign irq = |(irq_status & irq_enable);

   // ----------------------------------------------------------------
   // read channel, one cycle latency
   // ----------------------------------------------------------------
   logic [31:0] next_rdata;
   always_comb
   begin
      next_rdata = lpw_pkg::RST_WORD;
      unique case (s_axi_araddr)
         lpw_pkg::OFF_PORT1_WAKE_STATUS: next_rdata = port1_wake_status;
         lpw_pkg::OFF_PORT1_WAKE_ENABLE: next_rdata = port1_wake_enable;
         lpw_pkg::OFF_PERIPH_WAKE_STATUS: next_rdata = {29'h0, peripheral_wake_status};
         lpw_pkg::OFF_PERIPH_WAKE_ENABLE: next_rdata = {29'h0, peripheral_wake_enable};
         lpw_pkg::OFF_RAM_BANK_SHUTDOWN: next_rdata = {28'h0, ram_bank_shutdown};
         lpw_pkg::OFF_RETAINED_SCRATCH_A: next_rdata = retained_scratch_a;
         lpw_pkg::OFF_RETAINED_SCRATCH_B: next_rdata = retained_scratch_b;
         lpw_pkg::OFF_IRQ_STATUS: next_rdata = {30'h0, irq_status};
         lpw_pkg::OFF_IRQ_ENABLE: next_rdata = {30'h0, irq_enable};
         default: next_rdata = lpw_pkg::RST_WORD;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;
   logic [7:0] rd_addr;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= lpw_pkg::RST_WORD;
         s_axi_rresp <= lpw_pkg::RESP_OKAY;
         rd_addr <= 8'h00;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= addr_known(s_axi_araddr) ? lpw_pkg::RESP_OKAY : lpw_pkg::RESP_SLVERR;
         rd_addr <= s_axi_araddr;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   logic [31:0] fall_q;
   logic [2:0] rise_q;
   always_ff @(posedge aclk)
   begin
      fall_q <= pin_set;
      rise_q <= ev.periph_rise;
   end

   property p_pin_set;
      @(posedge aclk) disable iff (!aresetn) (|fall_q) |-> ((port1_wake_status & fall_q) == fall_q);
   endproperty
   a_pin_set: assert property (p_pin_set) else $error("pin edge did not set status");

   property p_pin_clear;
      @(posedge aclk) disable iff (!aresetn)
         (wr_p1s && (wbits[0]) && !pin_set[0]) |=> !port1_wake_status[0];
   endproperty
   a_pin_clear: assert property (p_pin_clear) else $error("pin status one did not clear");

   property p_pin_wake;
      @(posedge aclk) disable iff (!aresetn)
         (global_pin_wake_enable && |(port1_wake_status & port1_wake_enable & PIN_PRESENT)) |-> wake_request && wake_irq;
   endproperty
   a_pin_wake: assert property (p_pin_wake) else $error("enabled pin flag gave no wake");

   property p_absent_pin;
      @(posedge aclk) disable iff (!aresetn)
         (per_wake == 1'b0 && (port1_wake_status & port1_wake_enable & PIN_PRESENT) == 32'h0) |-> !wake_request;
   endproperty
   a_absent_pin: assert property (p_absent_pin) else $error("wake without enabled present source");

   property p_per_set;
      @(posedge aclk) disable iff (!aresetn) (|rise_q) |-> ((peripheral_wake_status & rise_q) == rise_q);
   endproperty
   a_per_set: assert property (p_per_set) else $error("peripheral event lost");

   property p_per_wake;
      @(posedge aclk) disable iff (!aresetn)
         (ev.periph_rise[0] && peripheral_wake_enable[0] && !wr_fire) |=> wake_irq;
   endproperty
   a_per_wake: assert property (p_per_wake) else $error("peripheral flag gave no interrupt");

   property p_ram_off;
      @(posedge aclk) disable iff (!aresetn)
         (wr_fire && aw_addr == lpw_pkg::OFF_RAM_BANK_SHUTDOWN && w_strb[0]) |=> (ram_bank_pair_off == $past(w_data[3:0]));
   endproperty
   a_ram_off: assert property (p_ram_off) else $error("ram shutdown not applied");

   property p_scratch_keep;
      @(posedge aclk) disable iff (!aresetn) !wr_fire |=> $stable(retained_scratch_a) && $stable(retained_scratch_b);
   endproperty
   a_scratch_keep: assert property (p_scratch_keep) else $error("scratch word changed without write");

   property p_reserved_zero;
      @(posedge aclk) disable iff (!aresetn)
         (s_axi_rvalid && rd_addr == lpw_pkg::OFF_RAM_BANK_SHUTDOWN) |-> (s_axi_rdata[31:4] == 28'h0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

   property p_merge;
      @(posedge aclk) disable iff (!aresetn) wake_request |-> (pin_wake || per_wake) ##0 wake_irq;
   endproperty
   a_merge: assert property (p_merge) else $error("wake and interrupt disagree");

   c_pin_wake: cover property (@(posedge aclk) disable iff (!aresetn) pin_wake ##1 wr_p1s);
   c_per_wake: cover property (@(posedge aclk) disable iff (!aresetn) per_wake);
   c_set_clear: cover property (@(posedge aclk) disable iff (!aresetn) wr_pws && |ev.periph_rise);
   c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);
endmodule // lpw_wake_regs

// ---- hw/lpw_wake_sync.sv ----
// two-flop synchronisers and edge detectors for pin and peripheral wake inputs
`timescale 1ns/1ps
module lpw_wake_sync
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [lpw_pkg::PIN_W-1:0] port1_pin,
   input wire logic [lpw_pkg::PERIPH_W-1:0] periph_wake,
   lpw_evt_if.src ev
);
   // ----------------------------------------------------------------
   // synchroniser chains
   // ----------------------------------------------------------------
   logic [lpw_pkg::PIN_W-1:0] pin_meta;
   logic [lpw_pkg::PIN_W-1:0] pin_sync;
   logic [lpw_pkg::PIN_W-1:0] pin_prev;
   logic [lpw_pkg::PERIPH_W-1:0] per_meta;
   logic [lpw_pkg::PERIPH_W-1:0] per_sync;
   logic [lpw_pkg::PERIPH_W-1:0] per_prev;

   // pins idle high, so the chain resets high to avoid a false fall
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_meta <= '1;
         pin_sync <= '1;
         pin_prev <= '1;
      end
      else
      begin
         pin_meta <= port1_pin;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // peripheral wake lines idle low
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         per_meta <= lpw_pkg::RST_PERIPH;
         per_sync <= lpw_pkg::RST_PERIPH;
         per_prev <= lpw_pkg::RST_PERIPH;
      end
      else
      begin
         per_meta <= periph_wake;
         per_sync <= per_meta;
         per_prev <= per_sync;
      end
   end

   // ----------------------------------------------------------------
   // edge pulses, one cycle each
   // ----------------------------------------------------------------
   assign ev.pin_fall = pin_prev & ~pin_sync;
   assign ev.periph_rise = per_sync & ~per_prev;
endmodule // lpw_wake_sync
